// File: ibsm_core.sv
module ibsm_core
  import ibsm_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             irq,
  output logic             wake
);

  // ***************************************************************************
  // Pin synchronisers
  // ***************************************************************************
  ibsm_bus_t meta_q, bus_q, prev_q;

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      meta_q <= '{scl: 1'b1, sda: 1'b1};
      bus_q  <= '{scl: 1'b1, sda: 1'b1};
      prev_q <= '{scl: 1'b1, sda: 1'b1};
    end
    else if (clk_en)
    begin
      meta_q <= '{scl: scl_i, sda: sda_i};
      bus_q  <= meta_q;
      prev_q <= bus_q;
    end

  wire logic start_det = prev_q.scl && bus_q.scl && prev_q.sda && !bus_q.sda;
  wire logic stop_det  = prev_q.scl && bus_q.scl && !prev_q.sda && bus_q.sda;
  wire logic scl_rise  = !prev_q.scl && bus_q.scl;
  wire logic scl_fall  = prev_q.scl && !bus_q.scl;

  // ***************************************************************************
  // Registers
  // ***************************************************************************
  logic [7:0]  ctl_q, addr_q, buf_q, shift_q;
  logic [1:0]  dir_q;
  logic        start_q, stop_q, data_q, rw_q, full_q;
  logic        irq_st_q, irq_en_q;
  logic [3:0]  bitcnt_q;
  logic        ack_q, match_q, tx_q, nack_q;
  ibsm_state_t state_q;

  wire logic       acc     = psel && penable;
  wire logic       wr      = acc && pwrite;
  wire logic       rd      = acc && !pwrite;
  wire logic       enabled = ctl_q[CTL_EN];
  wire logic [3:0] mode    = ctl_q[3:0];
  wire logic fw_mode  = (mode == MODE_FW_IDLE) || (mode == MODE_FW_SLV7) || (mode == MODE_FW_SLV10);
  wire logic slv_on   = enabled && ((mode == MODE_SLV7) || (mode == MODE_FW_SLV7) || (mode == MODE_FW_SLV10));
  // The count starts at zero, so the ninth clock ends at index eight.
  wire logic byte_end = slv_on && scl_fall && (bitcnt_q == ACK_SLOT - 4'h1) && (state_q != ST_IDLE);
  // An address that did not match must neither load the buffer nor raise an event.
  wire logic byte_ok  = byte_end && (state_q == ST_XFER || match_q);
  wire logic addr_hit = (shift_q[7:1] == addr_q[7:1]);
  wire logic ovf_cond = full_q || ctl_q[CTL_OVF];

  wire logic evt = enabled && (start_det || stop_det || byte_ok);

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      pready <= 1'b0;
    else if (clk_en)
      pready <= psel && !penable;

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      pslverr <= 1'b0;
    else if (clk_en)
      pslverr <= 1'b0;

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      ctl_q  <= CTL_RESET;
      addr_q <= ADDR_RESET;
      dir_q  <= DIR_RESET;
    end
    else if (clk_en)
    begin
      if (wr && pready && paddr == REG_CONTROL)
        ctl_q <= pwdata[7:0];
      if (byte_ok && ovf_cond && !tx_q)
        ctl_q[CTL_OVF] <= 1'b1;
      if (wr && pready && paddr == REG_ADDRESS)
        addr_q <= pwdata[7:0];
      if (wr && pready && paddr == REG_PINDIR)
        dir_q <= pwdata[1:0];
    end

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!enabled)
      begin
        start_q <= 1'b0;
        stop_q  <= 1'b0;
      end
      else if (start_det)
      begin
        start_q <= 1'b1;
        stop_q  <= 1'b0;
      end
      else if (stop_det)
      begin
        start_q <= 1'b0;
        stop_q  <= 1'b1;
      end
    end

  always_ff @(posedge mclk)
    if (clk_en)
    begin
      if (wr && pready && paddr == REG_BUFFER)
        buf_q <= pwdata[7:0];
      else if (byte_ok && !tx_q && !full_q)
        buf_q <= shift_q;
    end

  // ***************************************************************************
  // Slave receive and transmit path
  // ***************************************************************************
  // slave keeps receiving
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      state_q  <= ST_IDLE;
      bitcnt_q <= '0;
      shift_q  <= '0;
      ack_q    <= 1'b0;
      match_q  <= 1'b0;
      tx_q     <= 1'b0;
      rw_q     <= 1'b0;
      data_q   <= 1'b0;
      full_q   <= 1'b0;
      nack_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      if (rd && pready && paddr == REG_BUFFER)
        full_q <= 1'b0;
      if (!slv_on || stop_det)
      begin
        state_q  <= ST_IDLE;
        bitcnt_q <= '0;
        ack_q    <= 1'b0;
        tx_q     <= 1'b0;
      end
      else if (start_det)
      begin
        state_q  <= ST_ADDR;
        // The clock fall that closes the start wraps the count to zero.
        bitcnt_q <= '1;
        ack_q    <= 1'b0;
        tx_q     <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          ST_IDLE, ST_SKIP: ;
          ST_ADDR, ST_XFER:
          begin
            if (scl_rise && bitcnt_q < BITS_PER_BYTE)
              shift_q <= {shift_q[6:0], bus_q.sda};
            if (scl_rise && bitcnt_q == BITS_PER_BYTE && tx_q)
              nack_q <= bus_q.sda;
            if (scl_fall)
              bitcnt_q <= bitcnt_q + 4'h1;
            if (scl_fall && bitcnt_q == BITS_PER_BYTE - 4'h1)
            begin
              if (state_q == ST_ADDR)
              begin
                match_q <= addr_hit;
                ack_q   <= addr_hit && !ovf_cond;
              end
              else
                ack_q <= !tx_q && !ovf_cond;
            end
            if (byte_end)
            begin
              bitcnt_q <= '0;
              ack_q    <= 1'b0;
              if (state_q == ST_ADDR && !match_q)
                state_q <= ST_SKIP;
              else if (tx_q && nack_q)
                state_q <= ST_SKIP;
              else
              begin
                state_q <= ST_XFER;
                data_q  <= (state_q == ST_XFER);
                if (state_q == ST_ADDR)
                begin
                  rw_q <= shift_q[0];
                  tx_q <= shift_q[0];
                end
                if (!tx_q && !full_q)
                  full_q <= 1'b1;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end

  // ***************************************************************************
  // Interrupt and wake
  // ***************************************************************************
  // stop event raises interrupt
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      irq_st_q <= 1'b0;
      irq_en_q <= 1'b0;
      irq      <= 1'b0;
      wake     <= 1'b0;
    end
    else if (clk_en)
    begin
      if (evt)
        irq_st_q <= 1'b1;
      else if (wr && pready && paddr == REG_IRQ_ST && pwdata[IRQ_EVENT])
        irq_st_q <= 1'b0;
      if (wr && pready && paddr == REG_IRQ_EN)
        irq_en_q <= pwdata[IRQ_EVENT];
      irq <= irq_st_q && irq_en_q;
      wake <= byte_ok && irq_en_q;
    end

  // ***************************************************************************
  // Pin drive
  // ***************************************************************************
  wire logic stretch = slv_on && irq_st_q && !ctl_q[CTL_REL] && (state_q == ST_XFER);
  wire logic tx_bit  = tx_q && (state_q == ST_XFER) && bitcnt_q < BITS_PER_BYTE && !buf_q[3'(7 - bitcnt_q[2:0])];

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
    end
    else if (clk_en)
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= (enabled && fw_mode && !dir_q[DIR_SCL]) || stretch;
      sda_oe <= (enabled && fw_mode && !dir_q[DIR_SDA]) || ack_q || tx_bit;
    end

  // ***************************************************************************
  // Read mux
  // ***************************************************************************
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      prdata <= '0;
    else if (clk_en && psel && !penable)
    begin
      prdata <= '0;
      unique case (paddr)
        REG_BUFFER:  prdata[7:0] <= buf_q;
        REG_ADDRESS: prdata[7:0] <= addr_q;
        REG_CONTROL: prdata[7:0] <= ctl_q;
        REG_STATUS:
        begin
          prdata[ST_DATA]  <= data_q;
          prdata[ST_STOP]  <= stop_q;
          prdata[ST_START] <= start_q;
          prdata[ST_RW]    <= rw_q;
          prdata[ST_FULL]  <= full_q;
        end
        REG_PINDIR:  prdata[1:0] <= dir_q;
        REG_IRQ_ST:  prdata[IRQ_EVENT] <= irq_st_q;
        REG_IRQ_EN:  prdata[IRQ_EVENT] <= irq_en_q;
        default:     prdata <= '0;
      endcase
    end

  // ***************************************************************************
  // Checks
  // ***************************************************************************
  AST_FLAGS_CLR: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && !enabled |=> !start_q && !stop_q) else $error("flags not cleared");
  AST_LOW_DRIVE: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && enabled && fw_mode && !dir_q[DIR_SDA] |=> sda_oe && !sda_o) else $error("sda not low");
  AST_EVT_SET: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && evt |=> irq_st_q) else $error("event lost");
  sequence s_fw_released;
    clk_en && enabled && mode == MODE_FW_IDLE && dir_q == DIR_RESET;
  endsequence
  AST_MODE: assert property (@(posedge mclk) disable iff (sys_rst)
    s_fw_released ##1 s_fw_released |=> !sda_oe && !scl_oe) else $error("slave drove in idle mode");
  AST_STOP_IRQ: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && stop_det && enabled && irq_en_q ##1 clk_en |=> irq) else $error("no stop irq");
  AST_STRETCH: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && stretch |=> scl_oe) else $error("no stretch");
  AST_WAKE: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && byte_ok && irq_en_q |=> wake) else $error("no wake");
  AST_START: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en && start_det && enabled |=> start_q && !stop_q) else $error("start missed");

endmodule

// File: ibsm_pkg.sv
package ibsm_pkg;

  // ***************************************************************************
  // Register map (byte addresses, one aligned word each)
  // ***************************************************************************
  localparam logic [7:0] REG_BUFFER  = 8'h00;
  localparam logic [7:0] REG_ADDRESS = 8'h04;
  localparam logic [7:0] REG_CONTROL = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0C;
  localparam logic [7:0] REG_PINDIR  = 8'h10;
  localparam logic [7:0] REG_IRQ_ST  = 8'h14;
  localparam logic [7:0] REG_IRQ_EN  = 8'h18;

  // ***************************************************************************
  // Field positions
  // ***************************************************************************
  localparam int CTL_OVF   = 6;
  localparam int CTL_EN    = 5;
  localparam int CTL_REL   = 4;
  localparam int ST_DATA   = 5;
  localparam int ST_STOP   = 4;
  localparam int ST_START  = 3;
  localparam int ST_RW     = 2;
  localparam int ST_FULL   = 0;
  localparam int DIR_SCL   = 1;
  localparam int DIR_SDA   = 0;
  localparam int IRQ_EVENT = 0;

  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [1:0] DIR_RESET  = 2'h3;

  localparam logic [3:0] MODE_SLV7     = 4'h6;
  localparam logic [3:0] MODE_FW_IDLE  = 4'hB;
  localparam logic [3:0] MODE_FW_SLV7  = 4'hE;
  localparam logic [3:0] MODE_FW_SLV10 = 4'hF;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT      = 4'h9;

  // Sampled bus levels travel together.
  typedef struct packed {
    logic scl;
    logic sda;
  } ibsm_bus_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_XFER = 4'b0100,
    ST_SKIP = 4'b1000
  } ibsm_state_t;

endpackage

// File: ibsm_bus_model.sv
module ibsm_bus_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;

  logic lost;
  int   hang_n;

  // ****************************************
  // Far-side master, open drain: it only pulls.
  // ****************************************
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    lost    = 1'b0;
    hang_n  = 0;
  end

  task automatic start();
    sda_low = 1'b1;
    #62.5;
    scl_low = 1'b1;
    #62.5;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #62.5;
    scl_low = 1'b0;
    #62.5;
    sda_low = 1'b0;
    #62.5;
  endtask

  // A slave may stretch the clock, so the high phase starts only once the line has really risen.
  task automatic pulse(output logic seen);
    int n;
    scl_low = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 2000)
    begin
      #10;
      n++;
    end
    if (n >= 2000)
      hang_n++;
    #31;
    seen = sda;
    #31.5;
    scl_low = 1'b1;
    #62.5;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    lost = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      if (!lost)
      begin
        sda_low = ~b[i];
        pulse(s);
        // only a released bit can be overridden
        if (b[i] && s !== 1'b1)
        begin
          lost    = 1'b1;
          sda_low = 1'b0;
          scl_low = 1'b0;
        end
      end
    end
    if (!lost)
    begin
      sda_low = 1'b0;
      pulse(s);
      ack = ~s;
    end
    else
      ack = 1'b0;
  endtask
endmodule

// File: ibsm_core_bench.sv
module ibsm_core_bench
  import ibsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk;
  logic        sys_rst;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl_o;
  logic        scl_oe;
  logic        sda_o;
  logic        sda_oe;
  logic        irq;
  logic        wake;
  logic        m_scl_low;
  logic        m_sda_low;
  wire         scl_bus;
  wire         sda_bus;
  int          fail_count;
  int          n_checks;
  int          wake_n;
  logic [31:0] rng;
  logic        ack;
  logic [7:0]  exp_q[$];
  logic [3:0]  modes[3] = '{MODE_FW_IDLE, MODE_FW_SLV7, MODE_FW_SLV10};

  // Both lines have pull-ups: released means high.
  assign scl_bus = ~((scl_oe === 1'b1) | m_scl_low);
  assign sda_bus = ~((sda_oe === 1'b1) | m_sda_low);

  always #5 mclk = ~mclk;

  always @(posedge mclk)
    if (wake === 1'b1)
      wake_n++;

  ibsm_core i_dut (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .scl_i   (scl_bus),
    .scl_o   (scl_o),
    .scl_oe  (scl_oe),
    .sda_i   (sda_bus),
    .sda_o   (sda_o),
    .sda_oe  (sda_oe),
    .irq     (irq),
    .wake    (wake)
  );

  ibsm_bus_model i_bus (
    .scl     (scl_bus),
    .sda     (sda_bus),
    .scl_low (m_scl_low),
    .sda_low (m_sda_low)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_sim();
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    apb(1'b1, a, v, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    apb(1'b0, a, 32'h0, d);
    chk(d & m, exp);
  endtask

  task automatic settle();
    repeat (12) @(posedge mclk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rng = 32'h0001868C;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    rchk(REG_CONTROL, 32'hFFFFFFFF, 32'h0);
    rchk(REG_ADDRESS, 32'hFFFFFFFF, 32'h0);
    rchk(REG_STATUS, 32'hFFFFFFFF, 32'h0);
    rchk(REG_PINDIR, 32'hFFFFFFFF, 32'h3);
    rchk(8'h1C, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    foreach (modes[i])
    begin
      wr(REG_CONTROL, {24'h0, 4'h2, modes[i]});
      i_bus.start();
      settle();
      rchk(REG_STATUS, 32'h18, 32'h08);
      rchk(REG_IRQ_ST, 32'h1, 32'h1);
      wr(REG_IRQ_ST, 32'h1);
      wr(REG_IRQ_EN, 32'h1);
      settle();
      chk({31'h0, irq}, 32'h0);
      i_bus.stop();
      settle();
      chk({31'h0, irq}, 32'h1);
      rchk(REG_STATUS, 32'h18, 32'h10);
      // A frozen clock enable lets a whole start and stop pass unseen.
      clk_en <= 1'b0;
      @(posedge mclk);
      i_bus.start();
      i_bus.stop();
      @(posedge mclk);
      clk_en <= 1'b1;
      settle();
      rchk(REG_STATUS, 32'h18, 32'h10);
      wr(REG_CONTROL, 32'h0);
      wr(REG_IRQ_ST, 32'h1);
      wr(REG_IRQ_EN, 32'h0);
      settle();
      rchk(REG_STATUS, 32'h18, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    // Firmware makes its own start and stop through the direction bits.
    wr(REG_CONTROL, {24'h0, 4'h2, MODE_FW_IDLE});
    rchk(REG_STATUS, 32'h18, 32'h0);
    wr(REG_PINDIR, 32'h2);
    settle();
    chk({30'h0, scl_oe, sda_oe}, 32'h1);
    chk({30'h0, scl_o, sda_o}, 32'h0);
    rchk(REG_STATUS, 32'h18, 32'h08);
    wr(REG_PINDIR, 32'h0);
    settle();
    chk({30'h0, scl_oe, sda_oe}, 32'h3);
    wr(REG_PINDIR, 32'h2);
    wr(REG_PINDIR, 32'h3);
    settle();
    rchk(REG_STATUS, 32'h18, 32'h10);
    // Firmware holds data low, so the far master loses on its first one.
    wr(REG_PINDIR, 32'h2);
    i_bus.start();
    i_bus.send_byte(8'h80, ack);
    chk({31'h0, i_bus.lost}, 32'h1);
    chk({30'h0, m_scl_low, m_sda_low}, 32'h0);
    wr(REG_PINDIR, 32'h3);
    settle();
    i_bus.start();
    i_bus.send_byte(8'h80, ack);
    chk({31'h0, i_bus.lost}, 32'h0);
    chk({31'h0, ack}, 32'h0);
    i_bus.stop();
    settle();
    rchk(REG_STATUS, 32'h18, 32'h10);
    wr(REG_CONTROL, 32'h0);
    wr(REG_IRQ_ST, 32'h1);
    // Slave logic stays active beside firmware master mode.
    wr(REG_ADDRESS, 32'hFF);
    wr(REG_IRQ_EN, 32'h1);
    wr(REG_CONTROL, {24'h0, 4'h2, MODE_FW_SLV7});
    i_bus.start();
    i_bus.send_byte(8'hFE, ack);
    exp_q.push_back(8'hFE);
    chk({31'h0, ack}, 32'h1);
    settle();
    chk({31'h0, scl_oe}, 32'h1);
    rchk(REG_BUFFER, 32'hFF, {24'h0, exp_q.pop_front()});
    wr(REG_CONTROL, {24'h0, 4'h3, MODE_FW_SLV7});
    settle();
    chk({31'h0, scl_oe}, 32'h0);
    wr(REG_IRQ_ST, 32'h1);
    rng = xs(rng);
    wake_n = 0;
    i_bus.send_byte(rng[7:0], ack);
    exp_q.push_back(rng[7:0]);
    chk({31'h0, ack}, 32'h1);
    settle();
    chk(wake_n, 32'h1);
    rchk(REG_BUFFER, 32'hFF, {24'h0, exp_q[0]});
    wr(REG_IRQ_ST, 32'h1);
    i_bus.stop();
    i_bus.start();
    i_bus.send_byte({1'b0, rng[13:8], 1'b0}, ack);
    chk({31'h0, ack}, 32'h0);
    i_bus.stop();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rchk(REG_CONTROL, 32'hFF, 32'h0);
    rchk(REG_BUFFER, 32'hFF, {24'h0, exp_q.pop_front()});
    chk(i_bus.hang_n, 32'h0);
    end_sim();
  end

  initial
  begin
    #900000;
    fail_count++;
    end_sim();
  end
endmodule
